// File: src/pcss_top.sv
/*
 Peripheral clock source selectors behind an AXI4-Lite slave.
 Assumes all source clocks arrive as synchronous levels on clk.
*/
// Our own choice: the AXI4-Lite register port.
// How it works
// - Group C selector adds codes 4, 5, 6
// - Low-power group A: 2 bits, reset 1
// - Hibernate group A: same encoding, reset 1
// - Converter: group A, fast RC, lp HF
// - Watchdog zero: 3 bits, code 4 divided bus
// - Watchdog one: same four-way encoding
// - Serial port: code 0 off, four sources
// - System RTC: three low-frequency sources
// - Display driver: three low-frequency sources
// - Voltage DAC: off plus four sources
// - Pulse counter: off, lp group A, pin
// - Sensor HF selector: 2 bits, reset 1
// - Sensor HF: 1 fast RC, 2 lp HF
module pcss_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite write address and data
  input wire logic [pcss_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [pcss_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Source clocks
  input wire logic hf_rc_locked_osc,
  input wire logic hf_crystal_osc,
  input wire logic fast_startup_rc_osc,
  input wire logic lowpower_hf_rc_osc,
  input wire logic hf_rc_locked_retimed,
  input wire logic hf_crystal_retimed,
  input wire logic low_freq_rc_osc,
  input wire logic low_freq_xtal_osc,
  input wire logic ultra_low_freq_rc_osc,
  input wire logic bus_clock_div_by_1024,
  input wire logic active_group_a_clk,
  input wire logic counter_input_pin_zero,
  // Branch clocks
  output logic active_group_c_clk,
  output logic lowpower_group_a_clk,
  output logic hibernate_group_a_clk,
  output logic converter_clk,
  output logic watchdog_zero_clk,
  output logic watchdog_one_clk,
  output logic serial_port_clk,
  output logic system_rtc_zero_clk,
  output logic display_driver_clk,
  output logic voltage_dac_clk,
  output logic pulse_counter_clk,
  output logic sensor_if_hf_clk
);
  localparam int NB = pcss_pkg::NUM_BR;
  localparam logic [3:0] IDX_BUSY = 4'hc;
  localparam logic [3:0] IDX_NONE = 4'hd;

  logic [2:0] sel_r [NB];
  logic [2:0] sel_nxt [NB];
  logic [NB-1:0] br_clk;
  logic [NB-1:0] br_busy;
  logic [7:0] br_src [NB];
  logic [11:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [3:0] widx, ridx;

  function automatic logic [3:0] decode(input logic [11:0] a);
    logic [3:0] r;
    r = IDX_NONE;
    for (int i = 0; i < NB; i++)
      if (a[11:2] == pcss_pkg::BR_OFS[i][11:2])
        r = 4'(i);
    if (a[11:2] == pcss_pkg::OFS_BUSY[11:2])
      r = IDX_BUSY;
    return r;
  endfunction

  // Source vectors, bit position equals select code
  always_comb
  begin
    br_src[0] = {1'b0, hf_crystal_retimed, hf_rc_locked_retimed,
      lowpower_hf_rc_osc, fast_startup_rc_osc, hf_crystal_osc,
      hf_rc_locked_osc, 1'b0};
    br_src[1] = {4'h0, ultra_low_freq_rc_osc, low_freq_xtal_osc,
      low_freq_rc_osc, 1'b0};
    br_src[2] = br_src[1];
    br_src[3] = {4'h0, lowpower_hf_rc_osc, fast_startup_rc_osc,
      active_group_a_clk, 1'b0};
    br_src[4] = {3'h0, bus_clock_div_by_1024,
      ultra_low_freq_rc_osc, low_freq_xtal_osc,
      low_freq_rc_osc, 1'b0};
    br_src[5] = br_src[4];
    br_src[6] = {3'h0, low_freq_xtal_osc, low_freq_rc_osc,
      lowpower_hf_rc_osc, br_clk[0], 1'b0};
    br_src[7] = br_src[1];
    br_src[8] = br_src[1];
    br_src[9] = {3'h0, lowpower_hf_rc_osc, fast_startup_rc_osc,
      br_clk[1], active_group_a_clk, 1'b0};
    br_src[10] = {5'h0, counter_input_pin_zero, br_clk[1],
      1'b0};
    br_src[11] = {5'h0, lowpower_hf_rc_osc,
      fast_startup_rc_osc, 1'b0};
  end

  generate
    for (genvar g = 0; g < NB; g++)
    begin : gen_branch
      pcss_switch u_switch (
        .clk(clk),
        .rst(rst),
        .src(br_src[g]),
        .sel(sel_r[g]),
        .clk_out(br_clk[g]),
        .busy(br_busy[g])
      );
    end
  endgenerate

  assign widx = decode(awaddr_r);
  assign ridx = decode(s_axi_araddr);

  always_comb
  begin
    sel_nxt = sel_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    awready_nxt = awready_r;
    wready_nxt = wready_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (s_axi_awvalid && awready_r)
    begin
      awaddr_nxt = s_axi_awaddr;
      aw_got_nxt = 1'b1;
      awready_nxt = 1'b0;
    end
    if (s_axi_wvalid && wready_r)
    begin
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
      w_got_nxt = 1'b1;
      wready_nxt = 1'b0;
    end
    if (aw_got_r && w_got_r && !bvalid_r)
    begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = pcss_pkg::RESP_OKAY;
      if (widx == IDX_NONE)
        bresp_nxt = pcss_pkg::RESP_SLVERR;
      else if (widx != IDX_BUSY && wstrb_r[0])
        sel_nxt[widx] = wdata_r[2:0] &
          pcss_pkg::BR_MASK[widx];
    end
    if (bvalid_r && s_axi_bready)
    begin
      bvalid_nxt = 1'b0;
      awready_nxt = 1'b1;
      wready_nxt = 1'b1;
    end
    if (s_axi_arvalid && arready_r)
    begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rresp_nxt = pcss_pkg::RESP_OKAY;
      rdata_nxt = 32'h0;
      if (ridx == IDX_NONE)
        rresp_nxt = pcss_pkg::RESP_SLVERR;
      else if (ridx == IDX_BUSY)
        rdata_nxt[NB-1:0] = br_busy;
      else
        rdata_nxt[2:0] = sel_r[ridx];
    end
    if (rvalid_r && s_axi_rready)
    begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < NB; i++)
        sel_r[i] <= pcss_pkg::SEL_RESET;
      awaddr_r <= 12'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r <= 2'h0;
      rdata_r <= 32'h0;
    end
    else
    begin
      sel_r <= sel_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign active_group_c_clk = br_clk[0];
  assign lowpower_group_a_clk = br_clk[1];
  assign hibernate_group_a_clk = br_clk[2];
  assign converter_clk = br_clk[3];
  assign watchdog_zero_clk = br_clk[4];
  assign watchdog_one_clk = br_clk[5];
  assign serial_port_clk = br_clk[6];
  assign system_rtc_zero_clk = br_clk[7];
  assign display_driver_clk = br_clk[8];
  assign voltage_dac_clk = br_clk[9];
  assign pulse_counter_clk = br_clk[10];
  assign sensor_if_hf_clk = br_clk[11];

  chk_reset_value: assert property (
    @(posedge clk)
    rst |=> sel_r[11] == pcss_pkg::SEL_RESET &&
      sel_r[1] == pcss_pkg::SEL_RESET)
    else $error("selector not at reset code");

  chk_two_bit_field: assert property (
    @(posedge clk) disable iff (rst)
    !sel_r[10][2] && !sel_r[2][2] && !sel_r[7][2])
    else $error("two-bit selector holds bit 2");

  chk_write_lands: assert property (
    @(posedge clk) disable iff (rst)
    (aw_got_r && w_got_r && !bvalid_r && wstrb_r[0] &&
      widx == 4'h4)
    |=> sel_r[4] == $past(wdata_r[2:0]) && bvalid_r)
    else $error("watchdog zero selector write lost");

  chk_read_answer: assert property (
    @(posedge clk) disable iff (rst)
    (s_axi_arvalid && arready_r && ridx == 4'h1)
    |=> rvalid_r && rdata_r == {29'h0, $past(sel_r[1])})
    else $error("read answer wrong");

  chk_group_c_retimed: assert property (
    @(posedge clk) disable iff (rst)
    (!br_busy[0] && sel_r[0] == pcss_pkg::CODE_LOCK_RT &&
      $past(sel_r[0]) == pcss_pkg::CODE_LOCK_RT)
    |=> br_clk[0] == $past(hf_rc_locked_retimed))
    else $error("group C not on retimed source");

  chk_wdog_one_div: assert property (
    @(posedge clk) disable iff (rst)
    (!br_busy[5] && sel_r[5] == pcss_pkg::CODE_DIV1024 &&
      $past(sel_r[5]) == pcss_pkg::CODE_DIV1024)
    |=> br_clk[5] == $past(bus_clock_div_by_1024))
    else $error("watchdog one not on divided bus clock");

  chk_counter_pin: assert property (
    @(posedge clk) disable iff (rst)
    (!br_busy[10] && sel_r[10] == pcss_pkg::CODE_PIN &&
      $past(sel_r[10]) == pcss_pkg::CODE_PIN)
    |=> br_clk[10] == $past(counter_input_pin_zero))
    else $error("pulse counter not on input pin");

  chk_serial_gated: assert property (
    @(posedge clk) disable iff (rst)
    (!br_busy[6] && sel_r[6] == pcss_pkg::CODE_OFF &&
      $past(sel_r[6]) == pcss_pkg::CODE_OFF)
    |=> !br_clk[6])
    else $error("serial clock runs while gated off");
endmodule // pcss_top

// File: src/pcss_pkg.sv
/*
 Constants of the peripheral clock source selectors.
 Assumes a 12-bit byte address on the register bus.
*/
package pcss_pkg;
  localparam int ADDR_W = 12;
  localparam int NUM_BR = 12;
  localparam int SEL_W = 3;
  localparam int SRC_W = 8;
  localparam logic [11:0] OFS_GRP_C = 12'h128;
  localparam logic [11:0] OFS_LP_GRP_A = 12'h140;
  localparam logic [11:0] OFS_HIB_GRP_A = 12'h160;
  localparam logic [11:0] OFS_ADC = 12'h180;
  localparam logic [11:0] OFS_WDOG_ZERO = 12'h200;
  localparam logic [11:0] OFS_WDOG_ONE = 12'h208;
  localparam logic [11:0] OFS_SERIAL = 12'h220;
  localparam logic [11:0] OFS_RTC = 12'h240;
  localparam logic [11:0] OFS_DISPLAY = 12'h250;
  localparam logic [11:0] OFS_VOLT_DAC = 12'h260;
  localparam logic [11:0] OFS_PCNT = 12'h270;
  localparam logic [11:0] OFS_SENSOR = 12'h290;
  localparam logic [11:0] OFS_BUSY = 12'h2a0;
  localparam logic [11:0] BR_OFS [NUM_BR] = '{
    OFS_GRP_C, OFS_LP_GRP_A, OFS_HIB_GRP_A, OFS_ADC,
    OFS_WDOG_ZERO, OFS_WDOG_ONE, OFS_SERIAL, OFS_RTC,
    OFS_DISPLAY, OFS_VOLT_DAC, OFS_PCNT, OFS_SENSOR};
  // Two-bit fields mask off bit 2
  localparam logic [2:0] MASK2 = 3'h3;
  localparam logic [2:0] MASK3 = 3'h7;
  localparam logic [2:0] BR_MASK [NUM_BR] = '{
    MASK3, MASK2, MASK2, MASK2, MASK3, MASK3,
    MASK3, MASK2, MASK2, MASK3, MASK2, MASK2};
  localparam logic [2:0] SEL_RESET = 3'h1;
  localparam logic [2:0] CODE_OFF = 3'h0;
  localparam logic [2:0] CODE_DIV1024 = 3'h4;
  localparam logic [2:0] CODE_LOCK_RT = 3'h5;
  localparam logic [2:0] CODE_PIN = 3'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    PCSS_FOLLOW, PCSS_DRAIN, PCSS_JOIN
  } pcss_sw_type;
endpackage

// File: src/pcss_switch.sv
/*
 Glitch-free source switch for one clock branch.
 Assumes source levels are synchronous samples on clk.
*/
module pcss_switch (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Sources indexed by code, select code
  input wire logic [pcss_pkg::SRC_W-1:0] src,
  input wire logic [pcss_pkg::SEL_W-1:0] sel,
  // Branch clock and switch in progress
  output logic clk_out,
  output logic busy
);
  pcss_pkg::pcss_sw_type state_r, state_nxt;
  logic [pcss_pkg::SEL_W-1:0] cur_r, cur_nxt;
  logic out_r, out_nxt;

  always_comb
  begin
    state_nxt = state_r;
    cur_nxt = cur_r;
    out_nxt = out_r;
    case (state_r)
      pcss_pkg::PCSS_FOLLOW:
      begin
        out_nxt = src[cur_r];
        if (sel != cur_r)
          state_nxt = pcss_pkg::PCSS_DRAIN;
      end
      // Let the old source fall, never cut a high phase
      pcss_pkg::PCSS_DRAIN:
      begin
        out_nxt = out_r & src[cur_r];
        if (!out_r)
        begin
          cur_nxt = sel;
          state_nxt = pcss_pkg::PCSS_JOIN;
        end
      end
      // Join the new source only in its low phase
      pcss_pkg::PCSS_JOIN:
      begin
        out_nxt = 1'b0;
        cur_nxt = sel;
        if (sel == cur_r && !src[cur_r])
          state_nxt = pcss_pkg::PCSS_FOLLOW;
      end
      default:
      begin
        out_nxt = 1'b0;
        state_nxt = pcss_pkg::PCSS_JOIN;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r <= pcss_pkg::PCSS_JOIN;
      cur_r <= pcss_pkg::SEL_RESET;
      out_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cur_r <= cur_nxt;
      out_r <= out_nxt;
    end
  end

  assign clk_out = out_r;
  assign busy = (state_r != pcss_pkg::PCSS_FOLLOW);

  chk_rise_in_follow: assert property (
    @(posedge clk) disable iff (rst)
    $rose(out_r) |-> $past(state_r) == pcss_pkg::PCSS_FOLLOW)
    else $error("branch clock rose outside follow state");

  chk_join_held_low: assert property (
    @(posedge clk) disable iff (rst)
    (state_r == pcss_pkg::PCSS_JOIN) |=> !out_r)
    else $error("branch clock high while joining");
endmodule // pcss_switch

// File: tb/pcss_top_tb_top.sv
/*
 Self-checking bench for the peripheral clock source selectors.
 Assumes sources are synchronous levels, driven here from one counter.
*/
module pcss_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OFF = 12;
  localparam int CHC = 13;
  localparam int CHA = 14;
  localparam int NL = -1;
  // Expected source index per branch and code, NL for unlisted codes
  localparam int EXP_TAB [12][8] = '{
    '{NL, 0, 1, 2, 3, 4, 5, NL}, '{NL, 6, 7, 8, NL, NL, NL, NL},
    '{NL, 6, 7, 8, NL, NL, NL, NL}, '{NL, 10, 2, 3, NL, NL, NL, NL},
    '{NL, 6, 7, 8, 9, NL, NL, NL}, '{NL, 6, 7, 8, 9, NL, NL, NL},
    '{OFF, CHC, 3, 6, 7, NL, NL, NL}, '{NL, 6, 7, 8, NL, NL, NL, NL},
    '{NL, 6, 7, 8, NL, NL, NL, NL}, '{OFF, 10, CHA, 2, 3, NL, NL, NL},
    '{OFF, CHA, 11, NL, NL, NL, NL, NL}, '{NL, 2, 3, NL, NL, NL, NL, NL}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h0;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [11:0] s_axi_araddr = 12'h0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire logic s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  logic [7:0] cnt = 8'h0;
  wire logic [11:0] src;
  wire logic [11:0] br;
  int num_errors = 0;
  int check_count = 0;

  // Twelve distinct patterns of period 64
  function automatic logic [11:0] srcv(input logic [7:0] c);
    logic [11:0] v;
    for (int i = 0; i < 12; i++)
    begin
      v[i] = c[i % 4] ^ ((i >= 4) ? c[3 + i / 4] : 1'b0);
    end
    return v;
  endfunction

  assign src = srcv(cnt);

  pcss_top u_pcss_top (
    .clk(clk), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .hf_rc_locked_osc(src[0]), .hf_crystal_osc(src[1]),
    .fast_startup_rc_osc(src[2]), .lowpower_hf_rc_osc(src[3]),
    .hf_rc_locked_retimed(src[4]), .hf_crystal_retimed(src[5]),
    .low_freq_rc_osc(src[6]), .low_freq_xtal_osc(src[7]),
    .ultra_low_freq_rc_osc(src[8]), .bus_clock_div_by_1024(src[9]),
    .active_group_a_clk(src[10]), .counter_input_pin_zero(src[11]),
    .active_group_c_clk(br[0]), .lowpower_group_a_clk(br[1]),
    .hibernate_group_a_clk(br[2]), .converter_clk(br[3]),
    .watchdog_zero_clk(br[4]), .watchdog_one_clk(br[5]),
    .serial_port_clk(br[6]), .system_rtc_zero_clk(br[7]),
    .display_driver_clk(br[8]), .voltage_dac_clk(br[9]),
    .pulse_counter_clk(br[10]), .sensor_if_hf_clk(br[11])
  );

  initial
  begin
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cnt <= cnt + 8'h1;
  end

  task automatic check_word(input string what, input logic [31:0] exp,
                            input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_bit(input string what, input logic exp,
                           input logic got);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                           input logic [3:0] s, output logic [1:0] resp);
    int n;
    logic done;
    done = 1'b0;
    n = 0;
    resp = 2'h3;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done && n < 100)
    begin
      @(posedge clk);
      n++;
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
      begin
        resp = s_axi_bresp;
        done = 1'b1;
      end
    end
    s_axi_bready <= 1'b0;
    check_bit("write answered", 1'b1, done);
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
                          output logic [1:0] resp);
    int n;
    logic done;
    done = 1'b0;
    n = 0;
    d = 32'h0;
    resp = 2'h3;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done && n < 100)
    begin
      @(posedge clk);
      n++;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
      begin
        d = s_axi_rdata;
        resp = s_axi_rresp;
        done = 1'b1;
      end
    end
    s_axi_rready <= 1'b0;
    check_bit("read answered", 1'b1, done);
  endtask

  task automatic reg_check(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check_word("read resp", {30'h0, pcss_pkg::RESP_OKAY}, {30'h0, r});
    check_word("register value", exp, d);
  endtask

  task automatic wait_idle(input int b);
    int n;
    logic [31:0] d;
    logic [1:0] r;
    d = 32'hffffffff;
    n = 0;
    while (d[b] !== 1'b0 && n < 300)
    begin
      axi_read(pcss_pkg::OFS_BUSY, d, r);
      n++;
    end
    check_bit("switch settles", 1'b0, d[b]);
    repeat (2) @(posedge clk);
  endtask

  task automatic follow_check(input int b, input int e);
    logic [11:0] v;
    logic exp;
    repeat (64)
    begin
      @(negedge clk);
      v = (e == CHC || e == CHA) ? srcv(cnt - 8'h2) : srcv(cnt - 8'h1);
      exp = (e == OFF) ? 1'b0 : (e == CHC) ? v[0] : (e == CHA) ? v[6] : v[e];
      check_bit("branch clock", exp,
                br[b]);
    end
  endtask

  task automatic apply_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    check_word("branches in reset", 32'h0, {20'h0, br});
    rst <= 1'b0;
  endtask

  task automatic test_reset_values();
    for (int i = 0; i < 12; i++)
    begin
      reg_check(pcss_pkg::BR_OFS[i],
                32'h1);
    end
  endtask

  task automatic test_routing();
    logic [1:0] r;
    for (int b = 0; b < 12; b++)
    begin
      for (int c = 0; c < 8; c++)
      begin
        if (EXP_TAB[b][c] != NL)
        begin
          axi_write(pcss_pkg::BR_OFS[b], c, 4'hf, r);
          check_word("write resp", 32'h0, {30'h0, r});
          reg_check(pcss_pkg::BR_OFS[b], c);
          wait_idle(b);
          follow_check(b, EXP_TAB[b][c]);
        end
      end
      axi_write(pcss_pkg::BR_OFS[b], 32'h1, 4'hf, r);
      wait_idle(b);
    end
  endtask

  task automatic test_refused();
    logic [31:0] d;
    logic [1:0] r;
    axi_write(12'h130, 32'h1, 4'hf, r);
    check_word("unmapped write", {30'h0, pcss_pkg::RESP_SLVERR}, {30'h0, r});
    axi_read(12'h130, d, r);
    check_word("unmapped read", {30'h0, pcss_pkg::RESP_SLVERR}, {30'h0, r});
    check_word("unmapped data", 32'h0, d);
    axi_write(pcss_pkg::OFS_LP_GRP_A, 32'h2, 4'he, r);
    check_word("no strobe resp", 32'h0, {30'h0, r});
    reg_check(pcss_pkg::OFS_LP_GRP_A, 32'h1);
    axi_write(pcss_pkg::OFS_BUSY, 32'h0, 4'hf, r);
    check_word("status write", 32'h0, {30'h0, r});
  endtask

  task automatic test_midrun_reset();
    logic [1:0] r;
    axi_write(pcss_pkg::OFS_WDOG_ZERO, 32'h4, 4'hf, r);
    axi_write(pcss_pkg::OFS_SENSOR, 32'h2, 4'hf, r);
    apply_reset();
    test_reset_values();
  endtask

  task automatic complete_run();
    $display("Checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    apply_reset();
    test_reset_values();
    test_routing();
    test_refused();
    test_midrun_reset();
    complete_run();
  end

  initial
  begin
    repeat (60000) @(posedge clk);
    num_errors++;
    complete_run();
  end
endmodule // pcss_top_tb_top
